//--- tch_port.sv
module tch_port
	import tch_pkg::*;
#(
	parameter int ACK_CRIT_CYC = ACK_CRIT_CYC_DEF,
	parameter int ACK_STORE_CYC = ACK_STORE_CYC_DEF
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Two-wire bus, open drain; oe high pulls the line low
	input wire logic scl_in,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_oe,
	// Device status and configuration
	input wire logic boot_done,
	input wire logic [6:0] dev_addr,
	input wire logic [1:0] sleep_sel,
	// Register core
	output tch_core_req_s core_req,
	input wire tch_core_rsp_s core_rsp,
	// Nonvolatile store
	output logic store_start,
	output logic store_refused,
	input wire logic store_done,
	output logic port_busy,
	// Sensing scan
	input wire logic drop_en,
	input wire logic scan_start,
	input wire logic scan_end,
	output logic sample_keep,
	output logic sample_drop
);

	localparam logic [TMR_W-1:0] CRIT_LAST = TMR_W'(ACK_CRIT_CYC - 2);

	tch_port_s r, next_r;
	logic scl_rise, scl_fall, start_cond, stop_cond, own_addr, sleep_fast;

	assign scl_rise = !r.scl_q && scl_in;
	assign scl_fall = r.scl_q && !scl_in;
	// Bus is ignored entirely until boot completes
	assign start_cond = boot_done && r.scl_q && scl_in && r.sda_q && !sda_in;
	assign stop_cond = boot_done && r.scl_q && scl_in && !r.sda_q && sda_in;
	assign own_addr = (r.shreg[7:1] == dev_addr);
	assign sleep_fast = (sleep_sel == SLP_512HZ) || (sleep_sel == SLP_64HZ);

	always_comb begin
		next_r = r;
		next_r.scl_q = scl_in;
		next_r.sda_q = sda_in;
		next_r.store_go = 1'b0;
		next_r.store_ref = 1'b0;
		next_r.bus_act = start_cond;
		if (store_done) begin
			next_r.busy = 1'b0;
		end
		case (r.st)
			S_IDLE: begin
				next_r.scl_oe = 1'b0;
				next_r.sda_oe = 1'b0;
			end
			S_RX: begin
				if (scl_rise) begin
					next_r.shreg = {r.shreg[6:0], sda_in};
					next_r.bitcnt = r.bitcnt + 3'h1;
					if (r.bitcnt == BIT_LAST) begin
						next_r.st = S_RXEND;
					end
				end
			end
			S_RXEND: begin
				if (scl_fall) begin
					next_r.st = S_ACK;
					next_r.sda_oe = 1'b1;
					if (r.idx == IDX_ADDR) begin
						// Store in progress: own address is not acknowledged
						if (!own_addr || r.busy) begin
							next_r.st = S_IDLE;
							next_r.sda_oe = 1'b0;
						end else begin
							next_r.rw = r.shreg[0];
							next_r.idx = IDX_PTR;
						end
					end else if (r.busy) begin
						next_r.st = S_IDLE;
						next_r.sda_oe = 1'b0;
					end else if (r.idx == IDX_PTR) begin
						next_r.ptr = r.shreg;
						next_r.idx = IDX_DATA;
					end else if (r.ptr == CMD_REG && r.shreg == STORE_CODE) begin
						// Store is acknowledged at once, without the core
						if (sleep_fast) begin
							next_r.store_ref = 1'b1;
						end else begin
							next_r.store_go = 1'b1;
							next_r.busy = 1'b1;
						end
					end else begin
						// Hold the clock low until the core answers or the timer reaches CRIT_LAST
						next_r.st = S_WAIT;
						next_r.sda_oe = 1'b0;
						next_r.scl_oe = 1'b1;
						next_r.timer = '0;
						next_r.req = '{1'b1, 1'b1, r.ptr, r.shreg};
						next_r.ptr = r.ptr + 8'h01;
					end
				end
			end
			S_WAIT: begin
				next_r.timer = r.timer + TMR_W'(1);
				// Time out before the limit so the answer is never late
				if (core_rsp.ack || r.timer >= CRIT_LAST) begin
					next_r.req = '0;
					next_r.scl_oe = 1'b0;
					if (r.req.wr) begin
						next_r.st = S_ACK;
						next_r.sda_oe = 1'b1;
					end else begin
						next_r.st = S_TX;
						next_r.bitcnt = '0;
						next_r.shreg = core_rsp.ack ? core_rsp.data : IDLE_RDATA;
						next_r.sda_oe = core_rsp.ack ? !core_rsp.data[7]
							: !IDLE_RDATA[7];
					end
				end
			end
			S_ACK: begin
				if (scl_fall) begin
					next_r.sda_oe = 1'b0;
					next_r.bitcnt = '0;
					if (r.rw) begin
						next_r.st = S_WAIT;
						next_r.scl_oe = 1'b1;
						next_r.timer = '0;
						next_r.req = '{1'b1, 1'b0, r.ptr, 8'h00};
						next_r.ptr = r.ptr + 8'h01;
					end else begin
						next_r.st = S_RX;
					end
				end
			end
			S_TX: begin
				if (scl_fall) begin
					next_r.bitcnt = r.bitcnt + 3'h1;
					next_r.shreg = {r.shreg[6:0], 1'b0};
					next_r.sda_oe = !r.shreg[6];
					if (r.bitcnt == BIT_LAST) begin
						next_r.st = S_MACK;
						next_r.sda_oe = 1'b0;
					end
				end
			end
			S_MACK: begin
				if (scl_rise) begin
					next_r.more = !sda_in;
				end
				if (scl_fall) begin
					if (r.more && !r.busy) begin
						next_r.st = S_WAIT;
						next_r.scl_oe = 1'b1;
						next_r.timer = '0;
						next_r.req = '{1'b1, 1'b0, r.ptr, 8'h00};
						next_r.ptr = r.ptr + 8'h01;
					end else begin
						next_r.st = S_IDLE;
					end
				end
			end
			default: begin
				next_r.st = S_IDLE;
			end
		endcase
		if (start_cond) begin
			next_r.st = S_RX;
			next_r.bitcnt = '0;
			next_r.idx = IDX_ADDR;
			next_r.sda_oe = 1'b0;
		end else if (stop_cond) begin
			next_r.st = S_IDLE;
			next_r.sda_oe = 1'b0;
		end
		if (!boot_done) begin
			next_r.st = S_IDLE;
			next_r.scl_oe = 1'b0;
			next_r.sda_oe = 1'b0;
			// A request left open here would never be closed
			next_r.req = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r <= '{st: S_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
		end else begin
			r <= next_r;
		end
	end

	assign scl_oe = r.scl_oe;
	assign sda_oe = r.sda_oe;
	assign core_req = r.req;
	assign store_start = r.store_go;
	assign store_refused = r.store_ref;
	assign port_busy = r.busy;

	tch_drop u_drop (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.drop_en(drop_en),
		.scan_start(scan_start),
		.scan_end(scan_end),
		.bus_act(r.bus_act),
		.sample_keep(sample_keep),
		.sample_drop(sample_drop)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence store_seen;
		boot_done && r.st == S_RXEND && scl_fall
			&& r.idx == IDX_DATA && !r.busy
			&& r.ptr == CMD_REG && r.shreg == STORE_CODE;
	endsequence

	crit_stretch_bound_a: assert property (
		(r.st == S_WAIT) |-> (r.timer < TMR_W'(ACK_CRIT_CYC)))
		else $error("clock held past the acknowledge limit");

	store_ack_fast_a: assert property (
		store_seen |=> (sda_oe && r.st == S_ACK))
		else $error("store command not acknowledged at once");

	store_launch_a: assert property (
		(store_seen and !sleep_fast) |=> (store_start && port_busy))
		else $error("store not launched after acknowledge");

	busy_nack_a: assert property (
		(port_busy && r.st == S_RXEND && scl_fall && boot_done)
			|=> (!sda_oe && !core_req.valid))
		else $error("byte served while store in progress");

	busy_hold_a: assert property (
		(port_busy && !store_done) |=> port_busy)
		else $error("busy dropped before store completed");

	fast_sleep_refuse_a: assert property (
		store_refused |-> ($past(sleep_fast) && !store_start)
			##1 !port_busy[*2])
		else $error("store run at a fast sleep interval");

	boot_silent_a: assert property (
		!$past(boot_done) |-> (!scl_oe && !sda_oe))
		else $error("bus driven before boot completed");

endmodule // tch_port

//--- tch_pkg.sv
package tch_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int ACK_CRIT_US = 140;
	localparam int ACK_STORE_US = 100;
	// Longest times round down to whole cycles
	localparam int ACK_CRIT_CYC_DEF = (ACK_CRIT_US * 1000) / CLK_PERIOD_NS;
	localparam int ACK_STORE_CYC_DEF = (ACK_STORE_US * 1000) / CLK_PERIOD_NS;
	localparam int TMR_W = 16;

	// Command register and the value that launches a store
	localparam logic [7:0] CMD_REG = 8'ha0;
	localparam logic [7:0] STORE_CODE = 8'h01;
	localparam logic [7:0] IDLE_RDATA = 8'hff;

	// Sleep interval codes
	localparam logic [1:0] SLP_1HZ = 2'h0;
	localparam logic [1:0] SLP_8HZ = 2'h1;
	localparam logic [1:0] SLP_64HZ = 2'h2;
	localparam logic [1:0] SLP_512HZ = 2'h3;

	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] IDX_ADDR = 2'h0;
	localparam logic [1:0] IDX_PTR = 2'h1;
	localparam logic [1:0] IDX_DATA = 2'h2;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RX = 3'b001,
		S_RXEND = 3'b010,
		S_WAIT = 3'b011,
		S_ACK = 3'b100,
		S_TX = 3'b101,
		S_MACK = 3'b110
	} tch_state_e;

	// Request to the register core, held until answered or timed out
	typedef struct packed {
		logic valid;
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} tch_core_req_s;

	// Answer from the register core
	typedef struct packed {
		logic ack;
		logic [7:0] data;
	} tch_core_rsp_s;

	typedef struct packed {
		tch_state_e st;
		logic scl_q;
		logic sda_q;
		logic [2:0] bitcnt;
		logic [7:0] shreg;
		logic [1:0] idx;
		logic rw;
		logic more;
		logic [7:0] ptr;
		logic [TMR_W-1:0] timer;
		logic busy;
		logic store_go;
		logic store_ref;
		logic bus_act;
		logic scl_oe;
		logic sda_oe;
		tch_core_req_s req;
	} tch_port_s;

	typedef struct packed {
		logic scanning;
		logic hit;
		logic keep;
		logic drop;
	} tch_drop_s;

endpackage

//--- tch_drop.sv
module tch_drop
	import tch_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Scan and bus events
	input wire logic drop_en,
	input wire logic scan_start,
	input wire logic scan_end,
	input wire logic bus_act,
	// Verdict on each finished sample
	output logic sample_keep,
	output logic sample_drop
);

	tch_drop_s r, next_r;

	always_comb begin
		next_r = r;
		next_r.keep = 1'b0;
		next_r.drop = 1'b0;
		if (scan_start) begin
			next_r.scanning = 1'b1;
			next_r.hit = 1'b0;
		end
		// Traffic while the scan runs taints the sample; set wins
		if ((r.scanning || scan_start) && bus_act) begin
			next_r.hit = 1'b1;
		end
		if (scan_end && r.scanning) begin
			next_r.scanning = 1'b0;
			next_r.hit = 1'b0;
			if (drop_en && (r.hit || bus_act)) begin
				next_r.drop = 1'b1;
			end else begin
				next_r.keep = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign sample_keep = r.keep;
	assign sample_drop = r.drop;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	drop_on_traffic_a: assert property (
		(r.scanning && r.hit && drop_en && scan_end) |=> sample_drop)
		else $error("tainted sample was not dropped");

	keep_when_off_a: assert property (
		(r.scanning && !drop_en && scan_end) |=> (sample_keep && !sample_drop))
		else $error("sample dropped while filter disabled");

endmodule // tch_drop

//--- tch_host.sv
module tch_host
	import tch_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Device pull-downs
	input wire logic scl_oe,
	input wire logic sda_oe,
	// Line levels seen by all parties
	output logic scl_in,
	output logic sda_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic m_scl = 1'b1;
	logic m_sda = 1'b1;
	int stretch = 0;

	// Pull-ups: a released line reads high
	assign scl_in = m_scl & ~scl_oe;
	assign sda_in = m_sda & ~sda_oe;

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic start();
		m_sda <= 1'b0;
		tick(4);
		m_scl <= 1'b0;
		tick(4);
	endtask

	task automatic stop();
		m_sda <= 1'b0;
		tick(4);
		m_scl <= 1'b1;
		tick(4);
		m_sda <= 1'b1;
		tick(8);
	endtask

	// One bit slot; the device may hold the clock low
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		m_sda <= b;
		tick(4);
		m_scl <= 1'b1;
		stretch = 0;
		do begin
			@(negedge clk_sys);
			stretch++;
		end while (!scl_in && stretch < 5000);
		tick(2);
		@(negedge clk_sys);
		r = sda_in;
		tick(1);
		m_scl <= 1'b0;
	endtask

	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	task automatic rd_byte(input logic mack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(~mack, r);
	endtask
endmodule // tch_host

//--- tch_port_bench.sv
module tch_port_bench
	import tch_pkg::*;
#(
	parameter int CRIT = 40,
	parameter int STO = 30
);
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic boot_done = 1'b0;
	logic [6:0] dev_addr = 7'h2a;
	logic [1:0] sleep_sel = SLP_1HZ;
	logic store_done = 1'b0;
	logic drop_en = 1'b0;
	logic scan_start = 1'b0;
	logic scan_end = 1'b0;
	tch_core_rsp_s core_rsp = '0;
	tch_core_req_s core_req, last_req;
	logic scl_in, scl_oe, sda_in, sda_oe;
	logic store_start, store_refused, port_busy;
	logic sample_keep, sample_drop;
	logic [7:0] rd_val = 8'h00;
	logic [7:0] got;
	logic [2:0] acks;
	int core_lat = 0;
	int wait_n = 0;
	int n_go = 0;
	int n_ref = 0;
	int n_keep = 0;
	int n_drop = 0;
	int n_fail = 0;
	int compares = 0;

	initial forever #5 clk_sys = ~clk_sys;

	tch_port #(.ACK_CRIT_CYC(CRIT), .ACK_STORE_CYC(STO)) dut_u (
		.clk_sys(clk_sys), .rst_n(rst_n),
		.scl_in(scl_in), .scl_oe(scl_oe),
		.sda_in(sda_in), .sda_oe(sda_oe),
		.boot_done(boot_done), .dev_addr(dev_addr),
		.sleep_sel(sleep_sel),
		.core_req(core_req), .core_rsp(core_rsp),
		.store_start(store_start), .store_refused(store_refused),
		.store_done(store_done), .port_busy(port_busy),
		.drop_en(drop_en), .scan_start(scan_start),
		.scan_end(scan_end),
		.sample_keep(sample_keep), .sample_drop(sample_drop)
	);

	tch_host h (
		.clk_sys(clk_sys), .scl_oe(scl_oe), .sda_oe(sda_oe),
		.scl_in(scl_in), .sda_in(sda_in)
	);

	// Register core answers after core_lat cycles; data is junk otherwise
	always @(posedge clk_sys) begin
		n_go <= n_go + int'(store_start);
		n_ref <= n_ref + int'(store_refused);
		n_keep <= n_keep + int'(sample_keep);
		n_drop <= n_drop + int'(sample_drop);
		core_rsp <= '{1'b0, ~rd_val};
		wait_n <= 0;
		if (core_req.valid && !core_rsp.ack) begin
			wait_n <= wait_n + 1;
			if (wait_n == core_lat) begin
				core_rsp <= '{1'b1, rd_val};
				last_req <= core_req;
			end
		end
	end

	task automatic chk(input string w, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", w, e, g);
		end
	endtask

	task automatic wr3(input logic [7:0] p, input logic [7:0] d);
		h.start();
		h.wr_byte({dev_addr, 1'b0}, acks[2]);
		h.wr_byte(p, acks[1]);
		h.wr_byte(d, acks[0]);
		h.stop();
	endtask

	task automatic rd(input logic [7:0] p);
		logic a;
		h.start();
		h.wr_byte({dev_addr, 1'b0}, a);
		h.wr_byte(p, a);
		h.stop();
		h.start();
		h.wr_byte({dev_addr, 1'b1}, a);
		h.rd_byte(1'b0, got);
		h.stop();
	endtask

	task automatic t_access();
		core_lat = 5;
		wr3(8'h10, 8'h3c);
		chk("wr acks", 8'h07, 8'(acks));
		chk("core data", 8'h3c, last_req.data);
		chk("wr wait", 8'h01, 8'(h.stretch < CRIT));
		core_lat = 1000;
		wr3(8'h11, 8'h55);
		chk("slow acks", 8'h07, 8'(acks));
		chk("slow wait", 8'h01, 8'(h.stretch < CRIT));
		core_lat = 3;
		rd_val = 8'h5a;
		rd(8'h20);
		chk("rd data", 8'h5a, got);
		chk("rd addr", 8'h20, last_req.addr);
		h.start();
		h.wr_byte({dev_addr, 1'b1}, acks[2]);
		h.rd_byte(1'b1, got);
		chk("burst first", 8'h5a, got);
		rd_val = 8'hc3;
		h.rd_byte(1'b0, got);
		h.stop();
		chk("burst ack", 8'h01, 8'(acks[2]));
		chk("burst second", 8'hc3, got);
		chk("burst addr", 8'h22, last_req.addr);
		core_lat = 1000;
		rd(8'h21);
		chk("late rd", IDLE_RDATA, got);
		core_lat = 2;
	endtask

	task automatic t_store();
		int g, r;
		for (int s = 0; s < 4; s++) begin
			sleep_sel <= 2'(s);
			g = n_go;
			r = n_ref;
			wr3(CMD_REG, STORE_CODE);
			@(negedge clk_sys);
			chk("st acks", 8'h07, 8'(acks));
			chk("st wait", 8'h01, 8'(h.stretch < STO));
			chk("st go", 8'(s < 2), 8'(n_go - g));
			chk("st ref", 8'(s > 1), 8'(n_ref - r));
			chk("busy", 8'(s < 2), 8'(port_busy));
			@(posedge clk_sys);
			if (s < 2) begin
				sleep_sel <= SLP_512HZ;
				wr3(8'h10, 8'h01);
				chk("busy acks", 8'h00, 8'(acks));
				store_done <= 1'b1;
				@(posedge clk_sys);
				store_done <= 1'b0;
				repeat (2) @(posedge clk_sys);
				wr3(8'h10, 8'h01);
				chk("after acks", 8'h07, 8'(acks));
			end
		end
	endtask

	task automatic t_drop();
		int k, d;
		for (int i = 0; i < 4; i++) begin
			drop_en <= (i != 2);
			k = n_keep;
			d = n_drop;
			if (i == 3) begin
				h.start();
				h.stop();
			end
			scan_start <= 1'b1;
			@(posedge clk_sys);
			scan_start <= 1'b0;
			if (i == 0 || i == 2) begin
				h.start();
				h.stop();
			end else
				repeat (20) @(posedge clk_sys);
			scan_end <= 1'b1;
			@(posedge clk_sys);
			scan_end <= 1'b0;
			repeat (3) @(negedge clk_sys);
			chk("dropped", 8'(i == 0), 8'(n_drop - d));
			chk("kept", 8'(i != 0), 8'(n_keep - k));
			@(posedge clk_sys);
		end
	endtask

	task automatic report_and_stop();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		boot_done <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_access();
		t_store();
		t_drop();
		report_and_stop();
	end

	initial begin
		repeat (60000) @(posedge clk_sys);
		n_fail++;
		report_and_stop();
	end
endmodule // tch_port_bench
